// >>> logic/astg_pkg.sv
`default_nettype none
package astg_pkg;
    // APB register map, byte addresses.
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PIO = 8'h04;
    localparam logic [7:0] ADDR_MWDMA = 8'h08;
    localparam logic [7:0] ADDR_UDMA = 8'h0C;
    localparam logic [7:0] ADDR_PRESET = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // Control register fields.
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CLS_LSB = 1;
    localparam int CTRL_WR_BIT = 3;
    // Preset register fields.
    localparam int PRE_CLS_LSB = 0;
    localparam int PRE_MODE_LSB = 2;
    // Status register fields.
    localparam int STS_PH_LSB = 0;
    localparam int STS_STB_BIT = 4;
    localparam int STS_RDY_BIT = 5;
    localparam int STS_CNT_LSB = 16;

    typedef enum logic [1:0] {
        CLS_PIO = 2'b00,
        CLS_MWDMA = 2'b01,
        CLS_UDMA = 2'b10,
        CLS_NONE = 2'b11
    } astg_cls_t;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_ACTV = 3'b001,
        PH_RECV = 3'b010,
        PH_URUN = 3'b011,
        PH_UPAUSE = 3'b100
    } astg_phase_t;

    // One timing register: recovery setting in bits 15:8, assertion in 7:0.
    typedef struct packed {
        logic [7:0] rec;
        logic [7:0] asn;
    } astg_tmg_t;

    typedef struct packed {
        logic write;
        astg_cls_t cls;
        logic en;
    } astg_ctrl_t;

    // Clocks that hardware adds to each programmed setting.
    localparam logic [9:0] ASN_EXTRA = 10'h001;
    localparam logic [9:0] REC_EXTRA = 10'h002;
    localparam logic [9:0] UASN_EXTRA = 10'h002;
    localparam logic [9:0] UREC_EXTRA = 10'h001;
    localparam logic [9:0] UREC_TAIL = 10'h001;
    localparam logic [9:0] LEN_ONE = 10'h001;

    // Preset settings per transfer mode.
    localparam astg_tmg_t PIO0_TMG = '{rec: 8'h10, asn: 8'h11};
    localparam astg_tmg_t MW0_TMG = '{rec: 8'h0E, asn: 8'h0C};
    localparam astg_tmg_t MW1_TMG = '{rec: 8'h02, asn: 8'h04};
    localparam astg_tmg_t MW2_TMG = '{rec: 8'h01, asn: 8'h04};
    localparam int UD_MODES = 5;
    localparam logic [UD_MODES-1:0][7:0] UD_ASN = {8'h00, 8'h01, 8'h02, 8'h03, 8'h05};
    localparam logic [UD_MODES-1:0][7:0] UD_REC = {8'h05, 8'h05, 8'h05, 8'h07, 8'h09};
    localparam logic [2:0] MODE_1 = 3'h1;
    localparam logic [2:0] MODE_2 = 3'h2;
endpackage
`default_nettype wire

// >>> logic/astg_dncnt.sv
`timescale 1ns/10ps
`default_nettype none
// Phase timer: a load makes the next value-plus-one cycles one phase.
module astg_dncnt
    import astg_pkg::*;
#(
    parameter int CW = 9
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [CW-1:0] value,
    output logic expired
);
    typedef struct packed {
        logic [CW-1:0] cnt;
    } astg_cnt_t;

    astg_cnt_t q, d;

    always_comb
    begin
        d = q;
        if (load)
        begin
            d.cnt = value;
        end
        else if (q.cnt != '0)
        begin
            d.cnt = q.cnt - CW'(1);
        end
    end

    assign expired = (q.cnt == '0);

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// >>> logic/astg_strobe_gen.sv
// Overview of operation
// - Every interval is a whole number of core clock periods, counted by one timer.
// - In PIO and multiword DMA the strobe is active for assertion+1 and idle for recovery+2.
// - Multiword DMA mode 0 or any unlisted mode uses assertion 12 and recovery 14.
// - Multiword DMA modes 1 and 2 use assertion 4 with recovery 2 and 1 respectively.
// - In Ultra DMA write each strobe phase lasts assertion+2 and a pause recovery+1.
// - The Ultra DMA recovery exceeds its setting by at least two clocks: one in the pause phase, one passing through idle.
// - Ultra DMA recovery only applies when a transfer pauses, never between edges.
// - An Ultra DMA strobe cycle is two assertion intervals, one per edge.
// - PIO mode 0 uses assertion 17 and recovery 16, giving 18 clocks each.
`timescale 1ns/10ps
`default_nettype none
module astg_strobe_gen
    import astg_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic xferReq,
    input wire logic driveReady,
    output logic strobe,
    output logic busy
);
    typedef struct packed {
        astg_phase_t phase;
        logic strobe;
        logic busy;
        logic rdySync1;
        logic rdySync2;
        astg_ctrl_t ctrl;
        astg_tmg_t pio;
        astg_tmg_t mw;
        astg_tmg_t ud;
        logic [CNT_W-1:0] cycles;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [9:0] runLen;
    } astg_state_t;

    astg_state_t q, d;
    astg_tmg_t actTmg;
    astg_tmg_t preTmg;
    logic cntLoad;
    logic [8:0] cntVal;
    logic cntExp;
    logic run;
    logic udGo;
    logic access;
    logic wrTake;
    logic wrPreset;
    logic mapped;
    logic [31:0] rdVal;
    astg_cls_t preCls;
    logic [2:0] preMode;

    astg_dncnt #(
        .CW(9)
    ) u_timer (
        .core_clk(core_clk),
        .srst(srst),
        .load(cntLoad),
        .value(cntVal),
        .expired(cntExp)
    );

    // Preset table lookup for a written class and mode number.
    always_comb
    begin
        preCls = astg_cls_t'(pwdata[PRE_CLS_LSB +: 2]);
        preMode = pwdata[PRE_MODE_LSB +: 3];
        preTmg = PIO0_TMG;
        if (preCls == CLS_MWDMA)
        begin
            if (preMode == MODE_1)
            begin
                preTmg = MW1_TMG;
            end
            else if (preMode == MODE_2)
            begin
                preTmg = MW2_TMG;
            end
            else
            begin
                preTmg = MW0_TMG;
            end
        end
        else if (preCls == CLS_UDMA)
        begin
            if (preMode < 3'(UD_MODES))
            begin
                preTmg = '{rec: UD_REC[preMode], asn: UD_ASN[preMode]};
            end
            else
            begin
                preTmg = '{rec: UD_REC[0], asn: UD_ASN[0]};
            end
        end
    end

    always_comb
    begin
        unique case (q.ctrl.cls)
            CLS_MWDMA: actTmg = q.mw;
            CLS_UDMA: actTmg = q.ud;
            default: actTmg = q.pio;
        endcase
        // Ultra DMA runs only on writes; reads would need the drive's strobe.
        run = q.ctrl.en && xferReq && (q.ctrl.cls != CLS_NONE)
            && ((q.ctrl.cls != CLS_UDMA) || q.ctrl.write);
        udGo = run && (q.ctrl.cls == CLS_UDMA) && q.rdySync2;
        access = psel && penable;
        wrTake = access && q.pready && pwrite && !q.pslverr;
        wrPreset = wrTake && (paddr == ADDR_PRESET);
        mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_PIO) || (paddr == ADDR_MWDMA)
            || (paddr == ADDR_UDMA) || (paddr == ADDR_PRESET) || (paddr == ADDR_STATUS);
        rdVal = '0;
        unique case (paddr)
            ADDR_CTRL: rdVal = 32'(q.ctrl);
            ADDR_PIO: rdVal = 32'(q.pio);
            ADDR_MWDMA: rdVal = 32'(q.mw);
            ADDR_UDMA: rdVal = 32'(q.ud);
            ADDR_STATUS:
            begin
                rdVal[STS_PH_LSB +: 3] = q.phase;
                rdVal[STS_STB_BIT] = q.strobe;
                rdVal[STS_RDY_BIT] = q.rdySync2;
                rdVal[STS_CNT_LSB +: CNT_W] = q.cycles;
            end
            default: rdVal = '0;
        endcase
    end

    always_comb
    begin
        d = q;
        cntLoad = 1'b0;
        cntVal = '0;
        d.rdySync1 = driveReady;
        d.rdySync2 = q.rdySync1;

        // APB: one wait state, the access completes on the second access cycle.
        d.pready = access && !q.pready;
        if (access && !q.pready)
        begin
            d.pslverr = !mapped;
            d.prdata = pwrite ? 32'h0000_0000 : rdVal;
        end
        if (wrTake)
        begin
            unique case (paddr)
                ADDR_CTRL: d.ctrl = astg_ctrl_t'(pwdata[CTRL_EN_BIT +: 4]);
                ADDR_PIO: d.pio = astg_tmg_t'(pwdata[15:0]);
                ADDR_MWDMA: d.mw = astg_tmg_t'(pwdata[15:0]);
                ADDR_UDMA: d.ud = astg_tmg_t'(pwdata[15:0]);
                default: d.ctrl = q.ctrl;
            endcase
        end
        if (wrPreset)
        begin
            unique case (preCls)
                CLS_MWDMA: d.mw = preTmg;
                CLS_UDMA: d.ud = preTmg;
                default: d.pio = preTmg;
            endcase
        end

        // Strobe sequencer; a phase in progress always runs to its end.
        unique case (q.phase)
            PH_IDLE:
            begin
                if (udGo)
                begin
                    d.phase = PH_URUN;
                    d.strobe = !q.strobe;
                    cntLoad = 1'b1;
                    cntVal = 9'(10'(q.ud.asn) + UASN_EXTRA - LEN_ONE);
                end
                else if (run && (q.ctrl.cls != CLS_UDMA))
                begin
                    d.phase = PH_ACTV;
                    d.strobe = 1'b1;
                    cntLoad = 1'b1;
                    cntVal = 9'(10'(actTmg.asn) + ASN_EXTRA - LEN_ONE);
                end
            end
            PH_ACTV:
            begin
                if (cntExp)
                begin
                    d.phase = PH_RECV;
                    d.strobe = 1'b0;
                    cntLoad = 1'b1;
                    cntVal = 9'(10'(actTmg.rec) + REC_EXTRA - LEN_ONE);
                    d.cycles = q.cycles + CNT_W'(1);
                end
            end
            PH_RECV:
            begin
                if (cntExp && run && (q.ctrl.cls != CLS_UDMA))
                begin
                    d.phase = PH_ACTV;
                    d.strobe = 1'b1;
                    cntLoad = 1'b1;
                    cntVal = 9'(10'(actTmg.asn) + ASN_EXTRA - LEN_ONE);
                end
                else if (cntExp)
                begin
                    d.phase = PH_IDLE;
                end
            end
            PH_URUN:
            begin
                // Back-to-back edges never see the recovery count.
                if (cntExp && udGo)
                begin
                    d.strobe = !q.strobe;
                    cntLoad = 1'b1;
                    cntVal = 9'(10'(q.ud.asn) + UASN_EXTRA - LEN_ONE);
                    d.cycles = q.cycles + CNT_W'(1);
                end
                else if (cntExp)
                begin
                    d.phase = PH_UPAUSE;
                    cntLoad = 1'b1;
                    cntVal = 9'(10'(q.ud.rec) + UREC_EXTRA - LEN_ONE);
                end
            end
            PH_UPAUSE:
            begin
                // The pass through idle adds one clock beyond the setting.
                if (cntExp)
                begin
                    d.phase = PH_IDLE;
                end
            end
            default:
            begin
                d.phase = PH_IDLE;
            end
        endcase
        d.busy = (d.phase != PH_IDLE);
        d.runLen = (d.strobe != q.strobe) ? LEN_ONE
            : ((&q.runLen) ? q.runLen : q.runLen + LEN_ONE);
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            q <= '0;
            q.phase <= PH_IDLE;
            q.ctrl.cls <= CLS_PIO;
            q.pio <= PIO0_TMG;
            q.mw <= MW0_TMG;
            q.ud <= '{rec: UD_REC[0], asn: UD_ASN[0]};
        end
        else
        begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign strobe = q.strobe;
    assign busy = q.busy;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    pio_active_a: assert property (
        ($fell(q.strobe) && q.phase == PH_RECV)
        |-> $past(q.runLen) == 10'($past(actTmg.asn)) + ASN_EXTRA)
        else $error("Active strobe length differs from assertion setting plus one.");

    pio_recovery_a: assert property (
        ($rose(q.strobe) && $past(q.phase) == PH_RECV)
        |-> $past(q.runLen) == 10'($past(actTmg.rec)) + REC_EXTRA)
        else $error("Recovery length differs from recovery setting plus two.");

    udma_half_a: assert property (
        ($changed(q.strobe) && $past(q.phase) == PH_URUN)
        |-> $past(q.runLen) == 10'($past(q.ud.asn)) + UASN_EXTRA)
        else $error("Ultra DMA strobe phase differs from assertion setting plus two.");

    udma_norec_a: assert property (
        (q.phase == PH_URUN && cntExp && udGo) |=> $changed(q.strobe) && q.phase == PH_URUN)
        else $error("Ultra DMA edge delayed during continuous transfer.");

    udma_pause_a: assert property (
        $fell(q.phase == PH_UPAUSE)
        |-> $past(q.runLen) == 10'($past(q.ud.asn)) + 10'($past(q.ud.rec))
            + UASN_EXTRA + UREC_EXTRA)
        else $error("Ultra DMA pause recovery length is wrong.");

    timer_edge_a: assert property (
        ($changed(q.strobe) && $past(q.phase) != PH_IDLE) |-> $past(cntExp))
        else $error("Strobe moved before the phase timer expired.");

    udma_write_a: assert property (
        ($changed(q.strobe) && q.phase == PH_URUN) |-> $past(q.ctrl.write))
        else $error("Ultra DMA strobe driven on a read transfer.");

    preset_mw0_a: assert property (
        (wrPreset && preCls == CLS_MWDMA && preMode != MODE_1 && preMode != MODE_2)
        |=> q.mw == MW0_TMG)
        else $error("Multiword DMA mode 0 preset not loaded.");

    preset_mw2_a: assert property (
        (wrPreset && preCls == CLS_MWDMA && preMode == MODE_2) |=> q.mw == MW2_TMG)
        else $error("Multiword DMA mode 2 preset not loaded.");

    preset_pio_a: assert property (
        (wrPreset && preCls == CLS_PIO) |=> q.pio == PIO0_TMG)
        else $error("PIO mode 0 preset not loaded.");
endmodule
`default_nettype wire

// >>> tb/astg_drive_model.sv
`timescale 1ns/10ps
`default_nettype none
// Drive side of the cable: it holds off Ultra DMA bursts by lowering its ready line.
module astg_drive_model
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic pauseReq,
    output logic driveReady
);
    // A drive is not ready to take data until it has come out of reset.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            driveReady <= 1'b0;
        end
        else
        begin
            driveReady <= !pauseReq;
        end
    end
endmodule
`default_nettype wire

// >>> tb/ata_strobe_timing_generator_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ata_strobe_timing_generator_tb;
    import astg_pkg::*;
    logic core_clk;
    logic srst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic xferReq;
    logic pauseReq;
    logic driveReady;
    logic strobe;
    logic busy;
    int n_errors;
    int checks;
    int cycles;
    logic [31:0] rd;
    logic err;
    logic lvl;
    logic [15:0] cnt0;
    int len;
    int modes[6] = '{0, 1, 2, 5, 3, 4};
    logic [31:0] mwExp[4] = '{32'h0E0C, 32'h0204, 32'h0104, 32'h0E0C};
    logic [31:0] udExp[6] = '{32'h0905, 32'h0703, 32'h0502, 32'h0905, 32'h0501, 32'h0500};

    astg_strobe_gen i_dut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xferReq(xferReq), .driveReady(driveReady), .strobe(strobe),
        .busy(busy));
    astg_drive_model i_drive (.core_clk(core_clk), .srst(srst), .pauseReq(pauseReq),
        .driveReady(driveReady));

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = !core_clk;
    end

    task automatic end_of_test();
        if (n_errors == 0 && checks > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A hang anywhere in the sequence ends up here.
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask

    task automatic check_len(input string name, input int exp, input int got);
        checks++;
        if (got != exp)
        begin
            $display("ERROR %s expected %0d seen %0d", name, exp, got);
            n_errors++;
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
        output logic [31:0] rdata, output logic slverr);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdata = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] r;
        logic e;
        apb(1'b1, addr, data, r, e);
    endtask

    task automatic rdchk(input string name, input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, addr, 32'h0, r, e);
        check_word(name, exp, r);
        check_word("pslverr", 32'h0, {31'h0, e});
    endtask

    // Counts the cycles of the next stretch in which the strobe sits at the given level.
    task automatic hold_len(input logic level, output int n);
        #1;
        n = 0;
        while (strobe !== level && n < 600)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        n = 0;
        while (strobe === level && n < 600)
        begin
            n++;
            @(posedge core_clk);
            #1;
        end
    endtask

    // The phase in progress must end before the class changes under the sequencer.
    task automatic stop_run();
        @(posedge core_clk);
        xferReq <= 1'b0;
        while (busy !== 1'b0) @(posedge core_clk);
        wr(ADDR_CTRL, 32'h0);
    endtask

    task automatic run_timed(input logic [31:0] ctrl, input int expA, input int expR);
        int n;
        @(posedge core_clk);
        xferReq <= 1'b1;
        wr(ADDR_CTRL, ctrl);
        hold_len(1'b1, n);
        check_len("active clocks", expA, n);
        hold_len(1'b0, n);
        check_len("recovery clocks", expR, n);
        stop_run();
    endtask

    initial
    begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        xferReq = 1'b0;
        pauseReq = 1'b0;
        n_errors = 0;
        checks = 0;
        cycles = 0;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        rdchk("ctrl reset", ADDR_CTRL, 32'h0);
        rdchk("pio reset", ADDR_PIO, 32'h1011);
        rdchk("mwdma reset", ADDR_MWDMA, 32'h0E0C);
        rdchk("udma reset", ADDR_UDMA, 32'h0905);
        apb(1'b0, 8'h18, 32'h0, rd, err);
        check_word("unmapped pslverr", 32'h1, {31'h0, err});
        check_word("unmapped data", 32'h0, rd);
        rdchk("preset read", ADDR_PRESET, 32'h0);
        wr(ADDR_PIO, 32'h0);
        run_timed(32'h1, 1, 2);
        wr(ADDR_PRESET, 32'h0C);
        rdchk("pio preset", ADDR_PIO, 32'h1011);
        run_timed(32'h1, 18, 18);
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_MWDMA, 32'h0);
            wr(ADDR_PRESET, 32'h1 | (modes[i] << 2));
            rdchk("mwdma preset", ADDR_MWDMA, mwExp[i]);
        end
        run_timed(32'h3, 13, 16);
        wr(ADDR_PRESET, 32'h9);
        run_timed(32'h3, 5, 3);
        for (int i = 0; i < 6; i++)
        begin
            wr(ADDR_UDMA, 32'h0);
            wr(ADDR_PRESET, 32'h2 | (modes[i] << 2));
            rdchk("udma preset", ADDR_UDMA, udExp[i]);
        end
        @(posedge core_clk);
        xferReq <= 1'b1;
        wr(ADDR_CTRL, 32'h5);
        repeat (40) @(posedge core_clk);
        check_word("read udma strobe", 32'h0, {31'h0, strobe});
        check_word("read udma busy", 32'h0, {31'h0, busy});
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        check_word("idle status", 32'h0000_0020, {16'h0, rd[15:0]});
        cnt0 = rd[31:16];
        wr(ADDR_PRESET, 32'h6);
        wr(ADDR_CTRL, 32'hD);
        hold_len(1'b1, len);
        check_len("udma high phase", 5, len);
        hold_len(1'b0, len);
        check_len("udma low phase", 5, len);
        @(posedge core_clk);
        pauseReq <= 1'b1;
        repeat (20) @(posedge core_clk);
        lvl = strobe;
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        check_word("paused status", 32'h0000_0010, {16'h0, rd[15:0]});
        check_word("udma edges", {16'h0, cnt0 + 16'h0002}, {16'h0, rd[31:16]});
        repeat (16) @(posedge core_clk);
        check_word("paused strobe", {31'h0, lvl}, {31'h0, strobe});
        pauseReq <= 1'b0;
        hold_len(!lvl, len);
        check_len("udma phase after pause", 5, len);
        stop_run();
        end_of_test();
    end
endmodule
`default_nettype wire
